// File: logic/lfsc_map.svh
// constants of the led fault and status capture block
// Functional notes
// - status_select 10 without invisible mode stores short results when blank rises.
// - invisible mode stores short results at blank rise or at end of its working time, whichever comes first, instead.
// - short bit is one when output voltage exceeds selected short threshold.
// - open and short bits forced zero on off channels unless invisible mode.
// - nonzero invisible current sinks from blank fall until blank rise or timeout.
// - when invisible current stops, selected result type goes into status holder.
// - invisible current select 00 disables invisible mode.
// - leak detection stays inactive while invisible mode is enabled.
// - leak source current on off channels only with select 11 and blank low.
// - leak bit one for off channel below short threshold; on channels read zero.
// - leak results are stored in the status holder when blank rises.
// - latch edge with shift MSB zero copies data to on/off latch and loads status.
// - after a status load, latch edges are ignored until new data is shifted.
// - status shifts out on serial_out, one bit per shift clock rising edge.
// - over-temperature forces channels off and open bits to one until it clears.
// - thermal_error_flag stays one until next latch rising edge.
// - status all ones for error, warning, ref short at select 01, 10, 11.
// - ref_short_flag forces all sixteen channels off.
// - select 00 leaves the shift register unchanged at the latch edge.
// - open bit one on enabled channel whose voltage is below open threshold.
// - thermal_warning held until next latch edge; outputs stay on for it.
// - ref short sets all leak bits to one, outputs off until removed.
`ifndef LFSC_MAP_SVH
`define LFSC_MAP_SVH

`define LFSC_CH 16
`define LFSC_SR_W 17
`define LFSC_CLK_MHZ 250

// register byte addresses
`define LFSC_ADR_CTRL 4'h0
`define LFSC_ADR_STAT 4'h4
`define LFSC_ADR_ONOFF 4'h8
`define LFSC_CTRL_RST 8'h00
// link pin levels after reset: blank idles high, the rest low
`define LFSC_LNK_RST 4'h1

// status register field positions
`define LFSC_STAT_TEF 16
`define LFSC_STAT_WARN 17
`define LFSC_STAT_REF 18
`define LFSC_STAT_IDM 19

// status select codes
`define LFSC_SEL_NONE 2'h0
`define LFSC_SEL_OPEN 2'h1
`define LFSC_SEL_SHORT 2'h2
`define LFSC_SEL_LEAK 2'h3
`define LFSC_IDM_OFF 2'h0

// invisible working times in ns
`define LFSC_IDM_T0_NS 2000
`define LFSC_IDM_T1_NS 4000
`define LFSC_IDM_T2_NS 8000
`define LFSC_IDM_T3_NS 16000
`define LFSC_TMR_W 12

`endif

// File: logic/lfsc_pkg.sv
// types of the led fault and status capture block
package lfsc_pkg;

	// control fields written over the bus
	typedef struct packed {
		logic [1:0] short_threshold_sel;
		logic [1:0] invisible_time_sel;
		logic [1:0] invisible_current_sel;
		logic [1:0] status_select;
	} lfsc_cfg_t;

	// synchronised analog indications
	typedef struct packed {
		logic [15:0] below_open;
		logic [15:0] above_short;
		logic temp_error;
		logic temp_warn;
		logic ref_short;
	} lfsc_ind_t;

	// serial link pins
	typedef struct packed {
		logic shift_clock;
		logic serial_in;
		logic latch_strobe;
		logic output_blank;
	} lfsc_link_t;

	typedef enum logic {
		LFSC_IDM_IDLE,
		LFSC_IDM_RUN
	} lfsc_idm_st_t;

endpackage

// File: logic/lfsc_top.sv
// led fault detection and status capture with serial readout
`timescale 1ns/1ps
`include "lfsc_map.svh"

module lfsc_top #(
	parameter int CH = `LFSC_CH,
	parameter int SR_W = `LFSC_SR_W
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// serial link from the controller
	input wire logic shift_clock_i,
	input wire logic serial_in_i,
	input wire logic latch_strobe_i,
	input wire logic output_blank_i,
	output logic serial_out_o,
	// analog comparators and sensors
	input wire logic [15:0] below_open_i,
	input wire logic [15:0] above_short_i,
	input wire logic temp_error_i,
	input wire logic temp_warn_i,
	input wire logic ref_short_i,
	// analog controls
	output logic [15:0] channel_on_o,
	output logic invisible_current_en_o,
	output logic [1:0] invisible_current_sel_o,
	output logic [15:0] leak_source_en_o,
	output logic [1:0] short_threshold_sel_o
);

	generate
		if (CH != `LFSC_CH || SR_W != CH + 1) begin : g_chk
			$error("lfsc_top supports 16 channels and a 17 bit shift register only");
		end
		if ((`LFSC_IDM_T3_NS * `LFSC_CLK_MHZ) / 1000 >= (1 << `LFSC_TMR_W)) begin : g_tmr_chk
			$error("lfsc_top invisible working time does not fit the timer");
		end
	endgenerate

	localparam int IND_W = $bits(lfsc_pkg::lfsc_ind_t);
	localparam int LNK_W = $bits(lfsc_pkg::lfsc_link_t);

	// working time in cycles, rounded down, never below one
	function automatic logic [`LFSC_TMR_W-1:0] idm_cycles(input logic [1:0] sel);
		int ns;
		int cyc;
		unique case (sel)
			2'h0: ns = `LFSC_IDM_T0_NS;
			2'h1: ns = `LFSC_IDM_T1_NS;
			2'h2: ns = `LFSC_IDM_T2_NS;
			2'h3: ns = `LFSC_IDM_T3_NS;
		endcase
		cyc = (ns * `LFSC_CLK_MHZ) / 1000;
		if (cyc < 1) begin
			cyc = 1;
		end
		return cyc[`LFSC_TMR_W-1:0];
	endfunction

	// rising edge of a synchronised level
	function automatic logic edge_up(input logic now_lvl, input logic was_lvl);
		return now_lvl & ~was_lvl;
	endfunction

	// sticky flag: an active indication wins over the latch clear
	function automatic logic sticky_next(input logic cur_lvl, input logic set_lvl, input logic clr_lvl);
		if (set_lvl) begin
			return 1'b1;
		end
		return clr_lvl ? 1'b0 : cur_lvl;
	endfunction

	// synchronisers for pins and indications
	logic [IND_W-1:0] ind_meta_reg;
	logic [IND_W-1:0] ind_sync_reg;
	logic [LNK_W-1:0] lnk_meta_reg;
	logic [LNK_W-1:0] lnk_sync_reg;
	logic [LNK_W-1:0] lnk_prev_reg;
	lfsc_pkg::lfsc_ind_t ind;
	lfsc_pkg::lfsc_link_t lnk;
	lfsc_pkg::lfsc_link_t lnk_prev;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ind_meta_reg <= '0;
			ind_sync_reg <= '0;
		end else begin
			ind_meta_reg <= {below_open_i, above_short_i, temp_error_i, temp_warn_i, ref_short_i};
			ind_sync_reg <= ind_meta_reg;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lnk_meta_reg <= `LFSC_LNK_RST;
			lnk_sync_reg <= `LFSC_LNK_RST;
			lnk_prev_reg <= `LFSC_LNK_RST;
		end else begin
			lnk_meta_reg <= {shift_clock_i, serial_in_i, latch_strobe_i, output_blank_i};
			lnk_sync_reg <= lnk_meta_reg;
			lnk_prev_reg <= lnk_sync_reg;
		end
	end

	assign ind = ind_sync_reg;
	assign lnk = lnk_sync_reg;
	assign lnk_prev = lnk_prev_reg;

	logic sclk_rise;
	logic lat_rise;
	logic blank_rise;
	logic blank_fall;
	assign sclk_rise = edge_up(lnk.shift_clock, lnk_prev.shift_clock);
	assign lat_rise = edge_up(lnk.latch_strobe, lnk_prev.latch_strobe);
	assign blank_rise = edge_up(lnk.output_blank, lnk_prev.output_blank);
	assign blank_fall = edge_up(lnk_prev.output_blank, lnk.output_blank);

	// control register and bus slave
	lfsc_pkg::lfsc_cfg_t cfg_reg;
	logic ack_reg;
	logic [31:0] rdat_reg;
	logic [31:0] rdat_next;
	logic bus_req;
	logic bus_wr;
	logic bus_rd;
	assign bus_req = wb_cyc_i & wb_stb_i & ~ack_reg;
	assign bus_wr = bus_req && wb_we_i && wb_sel_i[0] && wb_adr_i == `LFSC_ADR_CTRL;
	assign bus_rd = bus_req && !wb_we_i;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg_reg <= `LFSC_CTRL_RST;
		end else if (bus_wr) begin
			cfg_reg <= wb_dat_i[7:0];
		end
	end

	logic idm_en;
	assign idm_en = cfg_reg.invisible_current_sel != `LFSC_IDM_OFF;

	// detector flags
	logic tef_flag_reg;
	logic warn_flag_reg;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tef_flag_reg <= 1'b0;
		end else begin
			tef_flag_reg <= sticky_next(tef_flag_reg, ind.temp_error, lat_rise);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			warn_flag_reg <= 1'b0;
		end else begin
			warn_flag_reg <= sticky_next(warn_flag_reg, ind.temp_warn, lat_rise);
		end
	end

	// invisible detection timer
	lfsc_pkg::lfsc_idm_st_t idm_st_reg;
	logic [`LFSC_TMR_W-1:0] tmr_reg;
	logic idm_run;
	logic idm_stop;
	assign idm_run = idm_st_reg == lfsc_pkg::LFSC_IDM_RUN;
	assign idm_stop = idm_run && (blank_rise || tmr_reg == '0 || !idm_en);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			idm_st_reg <= lfsc_pkg::LFSC_IDM_IDLE;
			tmr_reg <= '0;
		end else begin
			unique case (idm_st_reg)
				lfsc_pkg::LFSC_IDM_IDLE: begin
					if (blank_fall && idm_en) begin
						idm_st_reg <= lfsc_pkg::LFSC_IDM_RUN;
						tmr_reg <= idm_cycles(cfg_reg.invisible_time_sel) - 1'b1;
					end
				end
				lfsc_pkg::LFSC_IDM_RUN: begin
					if (blank_fall) begin
						tmr_reg <= idm_cycles(cfg_reg.invisible_time_sel) - 1'b1;
					end else if (idm_stop) begin
						idm_st_reg <= lfsc_pkg::LFSC_IDM_IDLE;
					end else begin
						tmr_reg <= tmr_reg - 1'b1;
					end
				end
			endcase
		end
	end

	// per-channel detector results
	logic [15:0] onoff_reg;
	logic [15:0] open_res;
	logic [15:0] short_res;
	logic [15:0] leak_res;
	logic [15:0] det_mask;
	assign det_mask = idm_en ? '1 : onoff_reg;
	assign open_res = ind.temp_error ? '1 : (ind.below_open & det_mask);
	assign short_res = ind.temp_warn ? '1 : (ind.above_short & det_mask);
	assign leak_res = ind.ref_short ? '1 : (idm_en ? '0 : (~ind.above_short & ~onoff_reg));

	// status holder capture
	logic [15:0] holder_reg;
	logic [15:0] holder_next;
	logic cap_now;
	always_comb begin
		unique case (cfg_reg.status_select)
			`LFSC_SEL_OPEN: holder_next = open_res;
			`LFSC_SEL_SHORT: holder_next = short_res;
			`LFSC_SEL_LEAK: holder_next = leak_res;
			`LFSC_SEL_NONE: holder_next = holder_reg;
		endcase
	end
	assign cap_now = idm_en ? idm_stop : blank_rise;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			holder_reg <= '0;
		end else if (cap_now) begin
			holder_reg <= holder_next;
		end
	end

	// status as loaded into the shift register, with flag overrides
	logic [15:0] load_val;
	always_comb begin
		load_val = holder_reg;
		unique case (cfg_reg.status_select)
			`LFSC_SEL_OPEN: load_val = tef_flag_reg ? '1 : holder_reg;
			`LFSC_SEL_SHORT: load_val = warn_flag_reg ? '1 : holder_reg;
			`LFSC_SEL_LEAK: load_val = ind.ref_short ? '1 : holder_reg;
			`LFSC_SEL_NONE: load_val = holder_reg;
		endcase
	end

	// common shift register and on/off latch
	logic [SR_W-1:0] sr_reg;
	logic data_new_reg;
	logic latch_ok;
	logic load_now;
	assign latch_ok = lat_rise && data_new_reg;
	assign load_now = latch_ok && !sr_reg[SR_W-1] && cfg_reg.status_select != `LFSC_SEL_NONE;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sr_reg <= '0;
		end else if (load_now) begin
			sr_reg[15:0] <= load_val;
		end else if (sclk_rise && !latch_ok) begin
			sr_reg <= {sr_reg[SR_W-2:0], lnk.serial_in};
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			data_new_reg <= 1'b0;
		end else if (load_now) begin
			data_new_reg <= 1'b0;
		end else if (sclk_rise && !latch_ok) begin
			data_new_reg <= 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			onoff_reg <= '0;
		end else if (latch_ok && !sr_reg[SR_W-1]) begin
			onoff_reg <= sr_reg[15:0];
		end
	end

	assign serial_out_o = sr_reg[SR_W-1];

	// channel sink enables
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			channel_on_o <= '0;
		end else if (ind.temp_error || ind.ref_short || lnk.output_blank) begin
			channel_on_o <= '0;
		end else begin
			channel_on_o <= onoff_reg;
		end
	end

	// leak test sources on turned-off channels
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			leak_source_en_o <= '0;
		end else if (cfg_reg.status_select == `LFSC_SEL_LEAK && !lnk.output_blank && !idm_en) begin
			leak_source_en_o <= ~onoff_reg;
		end else begin
			leak_source_en_o <= '0;
		end
	end

	// invisible detection current
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			invisible_current_en_o <= 1'b0;
		end else begin
			invisible_current_en_o <= idm_run && !idm_stop;
		end
	end

	assign invisible_current_sel_o = cfg_reg.invisible_current_sel;
	assign short_threshold_sel_o = cfg_reg.short_threshold_sel;

	// bus read data and acknowledge
	always_comb begin
		rdat_next = '0;
		unique case (wb_adr_i)
			`LFSC_ADR_CTRL: rdat_next[7:0] = cfg_reg;
			`LFSC_ADR_STAT: begin
				rdat_next[15:0] = holder_reg;
				rdat_next[`LFSC_STAT_TEF] = tef_flag_reg;
				rdat_next[`LFSC_STAT_WARN] = warn_flag_reg;
				rdat_next[`LFSC_STAT_REF] = ind.ref_short;
				rdat_next[`LFSC_STAT_IDM] = idm_run;
			end
			`LFSC_ADR_ONOFF: rdat_next[15:0] = onoff_reg;
			default: rdat_next = '0;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
			rdat_reg <= '0;
		end else begin
			ack_reg <= bus_req;
			if (bus_rd) begin
				rdat_reg <= rdat_next;
			end
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = rdat_reg;

endmodule

// File: verif/lfsc_chk.sv
// port assertions of the led fault and status capture block
`timescale 1ns/1ps
module lfsc_chk (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// watched ports
	input wire logic shift_clock_i,
	input wire logic output_blank_i,
	input wire logic serial_out_o,
	input wire logic temp_error_i,
	input wire logic ref_short_i,
	input wire logic [15:0] channel_on_o,
	input wire logic invisible_current_en_o,
	input wire logic [1:0] invisible_current_sel_o,
	input wire logic [15:0] leak_source_en_o
);
	logic [12:0] run_reg;
	default clocking dc @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	always_ff @(posedge clk_i) begin
		if (rst_i || !invisible_current_en_o) begin
			run_reg <= 13'h0;
		end else begin
			run_reg <= run_reg + 13'h1;
		end
	end
	property p_serial_out;
		!$stable(serial_out_o) |-> $past(shift_clock_i, 3);
	endproperty
	a_serial_out: assert property (p_serial_out) else $error("serial out moved without shift");
	property p_refoff;
		ref_short_i [*6] |-> channel_on_o == 16'h0;
	endproperty
	a_refoff: assert property (p_refoff) else $error("channel on during ref short");
	property p_hotoff;
		temp_error_i [*6] |-> channel_on_o == 16'h0;
	endproperty
	a_hotoff: assert property (p_hotoff) else $error("channel on while hot");
	property p_leakoff;
		(leak_source_en_o & channel_on_o) == 16'h0;
	endproperty
	a_leakoff: assert property (p_leakoff) else $error("leak source on lit channel");
	property p_leakblank;
		output_blank_i [*6] |-> leak_source_en_o == 16'h0;
	endproperty
	a_leakblank: assert property (p_leakblank) else $error("leak source while blanked");
	property p_leakidm;
		invisible_current_en_o |-> leak_source_en_o == 16'h0;
	endproperty
	a_leakidm: assert property (p_leakidm) else $error("leak source in invisible mode");
	property p_idmsel;
		invisible_current_sel_o == 2'h0 && $past(invisible_current_sel_o) == 2'h0 |-> !invisible_current_en_o;
	endproperty
	a_idmsel: assert property (p_idmsel) else $error("invisible current with select zero");
	property p_idmblank;
		output_blank_i [*6] |-> !invisible_current_en_o;
	endproperty
	a_idmblank: assert property (p_idmblank) else $error("invisible current while blanked");
	property p_idmlen;
		run_reg < 13'hfb0;
	endproperty
	a_idmlen: assert property (p_idmlen) else $error("invisible current too long");
endmodule
bind lfsc_top lfsc_chk chk (.clk_i, .rst_i, .shift_clock_i, .output_blank_i, .serial_out_o, .temp_error_i,
	.ref_short_i, .channel_on_o, .invisible_current_en_o, .invisible_current_sel_o, .leak_source_en_o);

// File: verif/lfsc_host.sv
// host model driving the serial link pins
`timescale 1ns/1ps
module lfsc_host (
	// clock
	input wire logic clk_i,
	// link pins
	input wire logic serial_out_i,
	output logic shift_clock_o,
	output logic serial_in_o,
	output logic latch_strobe_o,
	output logic output_blank_o
);
	initial begin
		shift_clock_o = 1'b0;
		serial_in_o = 1'b0;
		latch_strobe_o = 1'b0;
		output_blank_o = 1'b1;
	end
	task automatic w(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// shifts a frame msb first and returns what came out
	task automatic frame(input logic [16:0] d, output logic [16:0] q);
		for (int i = 16; i >= 0; i--) begin
			serial_in_o <= d[i];
			w(8);
			q[i] = serial_out_i;
			shift_clock_o <= 1'b1;
			w(8);
			shift_clock_o <= 1'b0;
		end
		w(8);
		serial_in_o <= ~d[0];
	endtask
	task automatic latch();
		latch_strobe_o <= 1'b1;
		w(8);
		latch_strobe_o <= 1'b0;
		w(8);
	endtask
	task automatic blank_pulse(input int n);
		output_blank_o <= 1'b0;
		w(n < 125 ? 125 : n);
		output_blank_o <= 1'b1;
		w(8);
	endtask
endmodule

// File: verif/tb_lfsc_top.sv
// testbench of the led fault and status capture block
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin miscompares++; $display("MISMATCH %0t got %h", $time, a); end end
module tb_lfsc_top;
	logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, serial_out_o, invisible_current_en_o;
	logic shift_clock_i, serial_in_i, latch_strobe_i, output_blank_i, temp_error_i, temp_warn_i, ref_short_i;
	logic [3:0] wb_adr_i, wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, r;
	logic [15:0] below_open_i, above_short_i, channel_on_o, leak_source_en_o, d, x;
	logic [1:0] invisible_current_sel_o, short_threshold_sel_o;
	logic [16:0] q;
	logic [10:0] tab[10] = '{11'h001, 11'h002, 11'h003, 11'h006, 11'h009, 11'h00e, 11'h01e, 11'h101, 11'h203, 11'h402};
	int miscompares = 0;
	int samples_checked = 0;
	int cyc = 0;
	lfsc_top uut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
		.wb_ack_o, .shift_clock_i, .serial_in_i, .latch_strobe_i, .output_blank_i, .serial_out_o, .below_open_i,
		.above_short_i, .temp_error_i, .temp_warn_i, .ref_short_i, .channel_on_o, .invisible_current_en_o,
		.invisible_current_sel_o, .leak_source_en_o, .short_threshold_sel_o);
	lfsc_host host (.clk_i, .serial_out_i(serial_out_o), .shift_clock_o(shift_clock_i), .serial_in_o(serial_in_i),
		.latch_strobe_o(latch_strobe_i), .output_blank_o(output_blank_i));
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	task automatic finish_test();
		$display("checked %0d mismatched %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			miscompares++;
			finish_test();
		end
	end
	task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] dw);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= dw;
		do begin
			@(posedge clk_i);
		end while (wb_ack_o !== 1'b1);
		r = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask
	function automatic logic [15:0] exp_sid(input logic [7:0] c);
		logic [15:0] m;
		m = c[3:2] != 2'h0 ? 16'hffff : d;
		case (c[1:0])
			2'h1: exp_sid = temp_error_i ? 16'hffff : below_open_i & m;
			2'h2: exp_sid = temp_warn_i ? 16'hffff : above_short_i & m;
			2'h3: exp_sid = ref_short_i ? 16'hffff : (c[3:2] != 2'h0 ? 16'h0 : ~d & ~above_short_i);
			default: exp_sid = 16'h0;
		endcase
	endfunction
	task automatic cap(input logic [10:0] t);
		logic [7:0] c;
		logic invisible_detect_mode;
		int n;
		c = t[7:0] | (8'($urandom) & 8'hc0);
		invisible_detect_mode = c[3:2] != 2'h0;
		n = c[3] ? 700 : 250;
		d = 16'($urandom);
		below_open_i <= 16'($urandom);
		above_short_i <= 16'($urandom);
		temp_error_i <= t[8];
		ref_short_i <= t[9];
		temp_warn_i <= t[10];
		wb(1'b1, 4'h0, {24'h0, c});
		host.frame({1'b0, d}, q);
		host.latch();
		fork
			host.blank_pulse(n);
			begin
				repeat (150) @(posedge clk_i);
				`CHK(channel_on_o, d & {16{~t[8] & ~t[9]}})
				`CHK(leak_source_en_o, (c[1:0] == 2'h3 && !invisible_detect_mode) ? ~d : 16'h0)
				repeat (n - 160) @(posedge clk_i);
				`CHK(invisible_current_en_o, invisible_detect_mode && n < (500 << c[5:4]))
				x = exp_sid(c);
				if (invisible_detect_mode && n > (500 << c[5:4])) begin
					below_open_i <= ~below_open_i;
					above_short_i <= ~above_short_i;
				end
			end
		join
		host.frame({1'b0, d}, q);
		host.latch();
		host.frame({1'b0, d}, q);
		`CHK(q, {1'b0, x})
		wb(1'b0, 4'h4, 32'h0);
		`CHK(r, {12'h0, 1'b0, t[9], t[10], t[8], x})
	endtask
	initial begin
		void'($urandom(42));
		{rst_i, wb_cyc_i, wb_stb_i, wb_we_i, temp_error_i, temp_warn_i, ref_short_i} = 7'h40;
		wb_adr_i = 4'h0;
		wb_sel_i = 4'hf;
		wb_dat_i = 32'h0;
		below_open_i = 16'h0;
		above_short_i = 16'h0;
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		wb(1'b0, 4'h0, 32'h0);
		`CHK(r, 32'h0)
		x = 16'($urandom);
		wb(1'b1, 4'h0, {24'h0, x[7:0]});
		wb_sel_i <= 4'he;
		wb(1'b1, 4'h0, {24'h0, ~x[7:0]});
		wb_sel_i <= 4'hf;
		wb(1'b0, 4'h0, 32'h0);
		`CHK(r, {24'h0, x[7:0]})
		`CHK({short_threshold_sel_o, invisible_current_sel_o}, {x[7:6], x[3:2]})
		wb(1'b0, 4'hc, 32'h0);
		`CHK(r, 32'h0)
		$display("regs done");
		foreach (tab[i]) begin
			cap(tab[i]);
			$display("capture %0d done", i);
		end
		wb(1'b1, 4'h0, 32'h0);
		host.frame({1'b0, d}, q);
		host.latch();
		host.frame({1'b1, ~d}, q);
		`CHK(q, {1'b0, d})
		host.latch();
		host.frame({1'b0, d}, q);
		`CHK(q, {1'b1, ~d})
		wb(1'b0, 4'h8, 32'h0);
		`CHK(r, {16'h0, d})
		$display("frames done");
		finish_test();
	end
endmodule
